//--- asr_params.svh
// Purpose: timing and field constants for the asynchronous SRAM write/retention controller
// Assumes: 50 MHz controller clock
// Notes: times in ns as printed, cycle counts derived from the clock period
`ifndef ASR_PARAMS_SVH
`define ASR_PARAMS_SVH

`define ASR_CLK_PERIOD_NS 20
`define ASR_ADDR_W 19
`define ASR_DATA_W 8
`define ASR_TIMER_W 4

// fast grade
`define ASR_WRITE_CYCLE_MIN_F_NS 55
`define ASR_SELECT_TO_WRITE_END_MIN_F_NS 50
`define ASR_ADDR_SETUP_MIN_F_NS 0
`define ASR_WRITE_PULSE_MIN_F_NS 40
`define ASR_WRITE_RECOVERY_MIN_F_NS 0
`define ASR_WRITE_TO_HIGHZ_MAX_F_NS 20
`define ASR_OE_TO_HIGHZ_MAX_F_NS 20
`define ASR_DATA_SETUP_MIN_F_NS 25
`define ASR_DATA_HOLD_MIN_F_NS 0
`define ASR_READ_CYCLE_MIN_F_NS 55

// slow grade
`define ASR_WRITE_CYCLE_MIN_S_NS 70
`define ASR_SELECT_TO_WRITE_END_MIN_S_NS 60
`define ASR_ADDR_SETUP_MIN_S_NS 0
`define ASR_WRITE_PULSE_MIN_S_NS 50
`define ASR_WRITE_RECOVERY_MIN_S_NS 0
`define ASR_WRITE_TO_HIGHZ_MAX_S_NS 25
`define ASR_OE_TO_HIGHZ_MAX_S_NS 25
`define ASR_DATA_SETUP_MIN_S_NS 30
`define ASR_DATA_HOLD_MIN_S_NS 0
`define ASR_READ_CYCLE_MIN_S_NS 70

`define ASR_DESELECT_TO_RETENTION_NS 0

// least time to whole cycles, rounded up, never below one
`define ASR_CYC_MIN(t) (((((t) + `ASR_CLK_PERIOD_NS - 1) / `ASR_CLK_PERIOD_NS) < 1) ? 1 : \
	(((t) + `ASR_CLK_PERIOD_NS - 1) / `ASR_CLK_PERIOD_NS))

`endif

//--- asr_pkg.sv
// Purpose: types for the asynchronous SRAM controller
// Assumes: nothing
// Notes: one-hot state codes
package asr_pkg;
	typedef enum logic [6:0] {
		ST_IDLE = 7'h01,
		ST_W_SETUP = 7'h02,
		ST_W_PULSE = 7'h04,
		ST_W_RECOV = 7'h08,
		ST_R_ACCESS = 7'h10,
		ST_RET = 7'h20,
		ST_RET_RECOV = 7'h40
	} asr_state_type;
endpackage

//--- asr_timer_if.sv
// Purpose: carrier between the controller sequencer and its phase timer
// Assumes: single clock
// Notes: load starts a phase of count cycles
`timescale 1ns/1ps
interface asr_timer_if #(parameter int W = 4);
	logic load;
	logic [W-1:0] count;
	logic done;
	modport ctrl (output load, output count, input done);
	modport tmr (input load, input count, output done);
endinterface

//--- asr_timer.sv
// Purpose: phase length timer, done in the last cycle of a loaded phase
// Assumes: count is at least one
// Notes: phase of N cycles when load is given on entry
`timescale 1ns/1ps
module asr_timer #(
	parameter int W = 4
) (
	input wire logic clk_in,
	input wire logic rst_in,
	asr_timer_if.tmr tif
);
	logic [W-1:0] cnt;

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			cnt <= '0;
		end else if (tif.load) begin
			cnt <= tif.count - {{(W-1){1'b0}}, 1'b1};
		end else if (cnt != '0) begin
			cnt <= cnt - {{(W-1){1'b0}}, 1'b1};
		end
	end

	assign tif.done = (cnt == '0);
endmodule

//--- asr_ctrl.sv
// Purpose: host-side controller driving an asynchronous 512K x 8 SRAM for write, read and retention
// Assumes: pin inputs synchronous to MCLK_IN; one request at a time
// Notes: OE held high during writes, so the memory never drives while data is driven
// Operation
// - write pulse at least grade minimum
// - select low long enough before write end
// - address valid before write begins
// - address held until write cycle end
// - pulse covers data setup plus turn-off
// - never drive against memory turn-off
// - no opposing data while memory outputs
// - deselect at retention, recover one read cycle
`timescale 1ns/1ps
`include "asr_params.svh"
module asr_ctrl #(
	parameter bit FAST_GRADE = 1'b1,
	parameter int ADDR_W = `ASR_ADDR_W,
	parameter int DATA_W = `ASR_DATA_W
) (
	input wire logic MCLK_IN,
	input wire logic RST_IN,
	input wire logic REQ_IN,
	input wire logic WR_IN,
	input wire logic [ADDR_W-1:0] ADDR_IN,
	input wire logic [DATA_W-1:0] WDATA_IN,
	input wire logic RETAIN_REQ_IN,
	input wire logic [DATA_W-1:0] SRAM_DQ_IN,
	output logic READY_OUT,
	output logic [DATA_W-1:0] RDATA_OUT,
	output logic RVALID_OUT,
	output logic WDONE_OUT,
	output logic RETAINED_OUT,
	output logic SRAM_CS_N_OUT,
	output logic SRAM_WE_N_OUT,
	output logic SRAM_OE_N_OUT,
	output logic [ADDR_W-1:0] SRAM_ADDR_OUT,
	output logic [DATA_W-1:0] SRAM_DQ_OUT,
	output logic SRAM_DQ_OE_N_OUT
);
	localparam int TW = `ASR_TIMER_W;
	localparam int WC_NS = FAST_GRADE ? `ASR_WRITE_CYCLE_MIN_F_NS : `ASR_WRITE_CYCLE_MIN_S_NS;
	localparam int CW_NS = FAST_GRADE ? `ASR_SELECT_TO_WRITE_END_MIN_F_NS : `ASR_SELECT_TO_WRITE_END_MIN_S_NS;
	localparam int AS_NS = FAST_GRADE ? `ASR_ADDR_SETUP_MIN_F_NS : `ASR_ADDR_SETUP_MIN_S_NS;
	localparam int WP_NS = FAST_GRADE ? `ASR_WRITE_PULSE_MIN_F_NS : `ASR_WRITE_PULSE_MIN_S_NS;
	localparam int WHZ_NS = FAST_GRADE ? `ASR_WRITE_TO_HIGHZ_MAX_F_NS : `ASR_WRITE_TO_HIGHZ_MAX_S_NS;
	localparam int OHZ_NS = FAST_GRADE ? `ASR_OE_TO_HIGHZ_MAX_F_NS : `ASR_OE_TO_HIGHZ_MAX_S_NS;
	localparam int DW_NS = FAST_GRADE ? `ASR_DATA_SETUP_MIN_F_NS : `ASR_DATA_SETUP_MIN_S_NS;
	localparam int RC_NS = FAST_GRADE ? `ASR_READ_CYCLE_MIN_F_NS : `ASR_READ_CYCLE_MIN_S_NS;

	// setup phase: select low, OE high, no drive, long enough for any prior output to float
	localparam int HZ_NS = (WHZ_NS > OHZ_NS) ? WHZ_NS : OHZ_NS;
	localparam int SU_NS = (HZ_NS > AS_NS) ? HZ_NS : AS_NS;
	localparam int SETUP_CYC = `ASR_CYC_MIN(SU_NS);
	localparam int P1_NS = (WP_NS > DW_NS) ? WP_NS : DW_NS;
	localparam int P2_NS = (P1_NS > (DW_NS + WHZ_NS)) ? P1_NS : (DW_NS + WHZ_NS);
	localparam int PULSE_NS = (P2_NS > CW_NS) ? P2_NS : CW_NS;
	localparam int PULSE_CYC = `ASR_CYC_MIN(PULSE_NS);
	localparam int WC_CYC = `ASR_CYC_MIN(WC_NS);
	localparam int RECOV_CYC = ((WC_CYC - SETUP_CYC - PULSE_CYC) < 1) ? 1 : (WC_CYC - SETUP_CYC - PULSE_CYC);
	localparam int RC_CYC = `ASR_CYC_MIN(RC_NS);

	asr_pkg::asr_state_type state;
	asr_pkg::asr_state_type next_state;
	logic [ADDR_W-1:0] addr_q;
	logic [DATA_W-1:0] wdata_q;
	logic take;

	asr_timer_if #(.W(TW)) tif ();

	asr_timer #(.W(TW)) u_timer (
		.clk_in(MCLK_IN),
		.rst_in(RST_IN),
		.tif(tif)
	);

	assign READY_OUT = (state == asr_pkg::ST_IDLE) && !RETAIN_REQ_IN;
	assign take = REQ_IN && READY_OUT;

	always_comb begin
		next_state = state;
		case (state)
			asr_pkg::ST_IDLE: begin
				if (RETAIN_REQ_IN) begin
					next_state = asr_pkg::ST_RET;
				end else if (REQ_IN) begin
					next_state = WR_IN ? asr_pkg::ST_W_SETUP : asr_pkg::ST_R_ACCESS;
				end
			end
			asr_pkg::ST_W_SETUP: begin
				if (tif.done) begin
					next_state = asr_pkg::ST_W_PULSE;
				end
			end
			asr_pkg::ST_W_PULSE: begin
				if (tif.done) begin
					next_state = asr_pkg::ST_W_RECOV;
				end
			end
			asr_pkg::ST_W_RECOV: begin
				if (tif.done) begin
					next_state = asr_pkg::ST_IDLE;
				end
			end
			asr_pkg::ST_R_ACCESS: begin
				if (tif.done) begin
					next_state = asr_pkg::ST_IDLE;
				end
			end
			asr_pkg::ST_RET: begin
				if (!RETAIN_REQ_IN) begin
					next_state = asr_pkg::ST_RET_RECOV;
				end
			end
			asr_pkg::ST_RET_RECOV: begin
				if (tif.done) begin
					next_state = asr_pkg::ST_IDLE;
				end
			end
			default: begin
				next_state = asr_pkg::ST_IDLE;
			end
		endcase
	end

	// phase timer loaded on each state change
	always_comb begin
		tif.load = (next_state != state);
		case (next_state)
			asr_pkg::ST_W_SETUP: tif.count = TW'(SETUP_CYC);
			asr_pkg::ST_W_PULSE: tif.count = TW'(PULSE_CYC);
			asr_pkg::ST_W_RECOV: tif.count = TW'(RECOV_CYC);
			asr_pkg::ST_R_ACCESS: tif.count = TW'(RC_CYC);
			asr_pkg::ST_RET_RECOV: tif.count = TW'(RC_CYC);
			default: tif.count = TW'(1);
		endcase
	end

	always_ff @(posedge MCLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			state <= asr_pkg::ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// request latch, held through the whole cycle
	always_ff @(posedge MCLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			addr_q <= '0;
			wdata_q <= '0;
		end else if (take) begin
			addr_q <= ADDR_IN;
			wdata_q <= WDATA_IN;
		end
	end

	// control pins, registered from the next state
	always_ff @(posedge MCLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			SRAM_CS_N_OUT <= 1'b1;
			SRAM_WE_N_OUT <= 1'b1;
			SRAM_OE_N_OUT <= 1'b1;
		end else begin
			SRAM_CS_N_OUT <= !((next_state == asr_pkg::ST_W_SETUP) || (next_state == asr_pkg::ST_W_PULSE) ||
				(next_state == asr_pkg::ST_R_ACCESS));
			SRAM_WE_N_OUT <= (next_state != asr_pkg::ST_W_PULSE);
			SRAM_OE_N_OUT <= (next_state != asr_pkg::ST_R_ACCESS);
		end
	end

	// address and data pins
	always_ff @(posedge MCLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			SRAM_ADDR_OUT <= '0;
			SRAM_DQ_OUT <= '0;
			SRAM_DQ_OE_N_OUT <= 1'b1;
		end else begin
			if (take) begin
				SRAM_ADDR_OUT <= ADDR_IN;
				SRAM_DQ_OUT <= WDATA_IN;
			end else begin
				SRAM_ADDR_OUT <= addr_q;
				SRAM_DQ_OUT <= wdata_q;
			end
			// drive only during the pulse and its recovery, memory outputs already off
			SRAM_DQ_OE_N_OUT <= !((next_state == asr_pkg::ST_W_PULSE) ||
				(next_state == asr_pkg::ST_W_RECOV));
		end
	end

	// read capture in the last access cycle
	always_ff @(posedge MCLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			RDATA_OUT <= '0;
			RVALID_OUT <= 1'b0;
		end else begin
			RVALID_OUT <= (state == asr_pkg::ST_R_ACCESS) && tif.done;
			if ((state == asr_pkg::ST_R_ACCESS) && tif.done) begin
				RDATA_OUT <= SRAM_DQ_IN;
			end
		end
	end

	always_ff @(posedge MCLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			WDONE_OUT <= 1'b0;
			RETAINED_OUT <= 1'b0;
		end else begin
			WDONE_OUT <= (state == asr_pkg::ST_W_RECOV) && tif.done;
			RETAINED_OUT <= (next_state == asr_pkg::ST_RET);
		end
	end
endmodule

//--- asr_sram_model.sv
// Purpose: behavioural model of the asynchronous 512K x 8 memory
// Assumes: one write lands at the end of each select and strobe overlap
// Notes: released data lines show the inverse of the last driven value
`timescale 1ns/1ps
module asr_sram_model (
	input wire logic cs_n_in,
	input wire logic we_n_in,
	input wire logic oe_n_in,
	input wire logic [18:0] addr_in,
	input wire logic [7:0] dq_in,
	output logic [7:0] dq_out
);
	logic [7:0] mem [logic [18:0]];
	logic [7:0] dq_val = 8'h00;
	wire wr_on = !cs_n_in && !we_n_in;
	wire drv = !cs_n_in && !oe_n_in && we_n_in;
	// contents kept whatever the other inputs do
	always @(negedge wr_on) begin
		mem[addr_in] = dq_in;
	end
	always @* begin
		if (drv)
			dq_val = mem.exists(addr_in) ? mem[addr_in] : 8'h5A;
	end
	assign dq_out = drv ? dq_val : ~dq_val;
endmodule

//--- asr_ctrl_sva.sv
// Purpose: pin timing checks for the memory controller
// Assumes: fast grade, 50 MHz clock
// Notes: sees top ports only
`timescale 1ns/1ps
module asr_ctrl_sva (
	input wire logic MCLK_IN,
	input wire logic RST_IN,
	input wire logic REQ_IN,
	input wire logic WR_IN,
	input wire logic READY_OUT,
	input wire logic RVALID_OUT,
	input wire logic WDONE_OUT,
	input wire logic RETAINED_OUT,
	input wire logic SRAM_CS_N_OUT,
	input wire logic SRAM_WE_N_OUT,
	input wire logic SRAM_OE_N_OUT,
	input wire logic [18:0] SRAM_ADDR_OUT,
	input wire logic [7:0] SRAM_DQ_OUT,
	input wire logic SRAM_DQ_OE_N_OUT
);
	default clocking cb @(posedge MCLK_IN); endclocking
	default disable iff (RST_IN);
	sequence s_take_wr;
		REQ_IN && READY_OUT && WR_IN;
	endsequence
	sequence s_take_rd;
		REQ_IN && READY_OUT && !WR_IN;
	endsequence
	AST_WP: assert property ($fell(SRAM_CS_N_OUT | SRAM_WE_N_OUT) |-> (!SRAM_CS_N_OUT && !SRAM_WE_N_OUT)[*3])
		else $error("write pulse too short");
	AST_CW: assert property ($rose(SRAM_WE_N_OUT) |-> $past(!SRAM_CS_N_OUT, 4))
		else $error("select low too short before write end");
	AST_ADDR: assert property (!SRAM_CS_N_OUT && $past(!SRAM_CS_N_OUT) |-> $stable(SRAM_ADDR_OUT))
		else $error("address moved while selected");
	AST_DSET: assert property (!SRAM_WE_N_OUT && $past(!SRAM_WE_N_OUT) |-> !SRAM_DQ_OE_N_OUT && $stable(SRAM_DQ_OUT))
		else $error("write data not steady");
	AST_DHOLD: assert property ($rose(SRAM_WE_N_OUT) |-> !SRAM_DQ_OE_N_OUT && $stable(SRAM_DQ_OUT))
		else $error("write data not held");
	AST_CONT: assert property (!SRAM_DQ_OE_N_OUT |-> SRAM_OE_N_OUT)
		else $error("data driven while memory outputs on");
	AST_WCYC: assert property (s_take_wr |-> ##6 WDONE_OUT)
		else $error("write cycle length wrong");
	AST_RCYC: assert property (s_take_rd |-> ##4 RVALID_OUT)
		else $error("read cycle length wrong");
	AST_RET: assert property (RETAINED_OUT |-> SRAM_CS_N_OUT)
		else $error("selected in retention");
	AST_RREC: assert property ($fell(RETAINED_OUT) |-> (!READY_OUT)[*3])
		else $error("retention recovery too short");
endmodule
bind asr_ctrl asr_ctrl_sva u_sva (.MCLK_IN(MCLK_IN), .RST_IN(RST_IN), .REQ_IN(REQ_IN), .WR_IN(WR_IN),
	.READY_OUT(READY_OUT), .RVALID_OUT(RVALID_OUT), .WDONE_OUT(WDONE_OUT), .RETAINED_OUT(RETAINED_OUT),
	.SRAM_CS_N_OUT(SRAM_CS_N_OUT), .SRAM_WE_N_OUT(SRAM_WE_N_OUT), .SRAM_OE_N_OUT(SRAM_OE_N_OUT),
	.SRAM_ADDR_OUT(SRAM_ADDR_OUT), .SRAM_DQ_OUT(SRAM_DQ_OUT), .SRAM_DQ_OE_N_OUT(SRAM_DQ_OE_N_OUT));

//--- asr_ctrl_tb_top.sv
// Purpose: self-checking bench for the memory controller
// Assumes: fast grade, memory model on the pins
// Notes: requests start at a falling edge
`timescale 1ns/1ps
module asr_ctrl_tb_top;
	logic mclk = 1'b0, rst = 1'b1, req = 1'b0, wr = 1'b0, retain = 1'b0;
	logic [18:0] addr = 19'h00000;
	logic [7:0] wdata = 8'h00;
	logic ready, rvalid, wdone, retained, cs_n, we_n, oe_n, dq_oe_n;
	logic [7:0] rdata, dq_ctrl;
	logic [18:0] maddr;
	wire [7:0] dq_mem;
	wire [7:0] dq_bus = dq_oe_n ? dq_mem : dq_ctrl;
	int fail_count = 0;
	int total_checks = 0;
	asr_ctrl dut (.MCLK_IN(mclk), .RST_IN(rst), .REQ_IN(req), .WR_IN(wr), .ADDR_IN(addr), .WDATA_IN(wdata),
		.RETAIN_REQ_IN(retain), .SRAM_DQ_IN(dq_bus), .READY_OUT(ready), .RDATA_OUT(rdata), .RVALID_OUT(rvalid),
		.WDONE_OUT(wdone), .RETAINED_OUT(retained), .SRAM_CS_N_OUT(cs_n), .SRAM_WE_N_OUT(we_n),
		.SRAM_OE_N_OUT(oe_n), .SRAM_ADDR_OUT(maddr), .SRAM_DQ_OUT(dq_ctrl), .SRAM_DQ_OE_N_OUT(dq_oe_n));
	asr_sram_model mem (.cs_n_in(cs_n), .we_n_in(we_n), .oe_n_in(oe_n), .addr_in(maddr), .dq_in(dq_bus),
		.dq_out(dq_mem));
	always #10 mclk = ~mclk;
	task automatic final_report();
		if (fail_count == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD %0t data %h want %h", $time, got, exp);
		end
	endtask
	task automatic chk1(input logic got, input logic exp);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD %0t flag %b want %b", $time, got, exp);
		end
	endtask
	// entered at a falling edge, returns at one
	task automatic access(input logic w, input logic [18:0] a, input logic [7:0] d);
		int n;
		n = 0;
		while (ready !== 1'b1 && n < 50) begin
			@(negedge mclk);
			n++;
		end
		wr = w;
		addr = a;
		wdata = d;
		req = 1'b1;
		@(negedge mclk);
		req = 1'b0;
		n = 0;
		while ((w ? wdone : rvalid) !== 1'b1 && n < 20) begin
			@(negedge mclk);
			n++;
		end
		chk1(w ? wdone : rvalid, 1'b1);
	endtask
	task automatic read_chk(input logic [18:0] a, input logic [7:0] exp);
		access(1'b0, a, 8'h00);
		chk8(rdata, exp);
	endtask
	task automatic t_write_read();
		access(1'b1, 19'h00000, 8'h3C);
		access(1'b1, 19'h7FFFF, 8'hC3);
		access(1'b1, 19'h12345, 8'hFF);
		access(1'b1, 19'h00000, 8'h81);
		read_chk(19'h7FFFF, 8'hC3);
		read_chk(19'h00000, 8'h81);
		read_chk(19'h12345, 8'hFF);
	endtask
	task automatic t_retention();
		retain = 1'b1;
		repeat (2) @(negedge mclk);
		chk1(retained, 1'b1);
		chk1(cs_n, 1'b1);
		chk1(ready, 1'b0);
		wr = 1'b1;
		addr = 19'h00000;
		wdata = 8'h00;
		req = 1'b1;
		repeat (3) @(negedge mclk);
		req = 1'b0;
		retain = 1'b0;
		@(negedge mclk);
		chk1(retained, 1'b0);
		read_chk(19'h00000, 8'h81);
		read_chk(19'h7FFFF, 8'hC3);
	endtask
	initial begin
		#100000;
		fail_count++;
		final_report();
	end
	initial begin
		repeat (12) @(negedge mclk);
		chk1(cs_n, 1'b1);
		chk1(we_n, 1'b1);
		chk1(oe_n, 1'b1);
		chk1(dq_oe_n, 1'b1);
		rst = 1'b0;
		@(negedge mclk);
		t_write_read();
		t_retention();
		final_report();
	end
endmodule
